/* bench/fcs_arr_model.sv */
// partner: flash array model that counts erases and can fail one
`default_nettype none
module fcs_arr_model (
  input  wire logic clk,           // clock
  input  wire logic arst_n,        // reset, active low
  input  wire logic arr_erase,     // erase pulse
  input  wire logic arr_erase_all, // whole-array erase
  input  wire logic fail_arm,      // bench asks for a failure
  output var  logic op_fail,       // failure level
  output var  int   n_erase,       // erases seen
  output var  logic last_all       // kind of last erase
);
  // ----------------------------------------
  // array behaviour
  // ----------------------------------------
  int cnt_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      n_erase  <= 0;
      last_all <= 1'b0;
      cnt_q    <= -1;
      op_fail  <= 1'b0;
    end else begin
      if (arr_erase) begin
        n_erase  <= n_erase + 1;
        last_all <= arr_erase_all;
        cnt_q    <= 0;
      end else if (cnt_q >= 0 && cnt_q < 1000) cnt_q <= cnt_q + 1;
      // fail late in the erase, hold while armed
      op_fail <= fail_arm && (op_fail || cnt_q == 420);
    end
  end
endmodule : fcs_arr_model
`default_nettype wire

/* bench/fcs_seq_chk.sv */
// checker: port-level assertions for the flash command sequencer
`default_nettype none
module fcs_seq_chk (
  input wire logic        clk,           // clock
  input wire logic        arst_n,        // reset, active low
  input wire logic        hsel,          // slave select
  input wire logic [31:0] haddr,         // address
  input wire logic [1:0]  htrans,        // transfer type
  input wire logic        hwrite,        // write
  input wire logic        hready,        // bus ready
  input wire logic [31:0] hrdata,        // read data
  input wire logic        hreadyout,     // slave ready
  input wire logic        hresp,         // response
  input wire logic        arr_erase,     // erase pulse
  input wire logic        arr_erase_all, // whole-array erase
  input wire logic        secure         // secure state
);
  // ----------------------------------------
  // helpers and properties
  // ----------------------------------------
  logic        rd_any;
  logic        rd0;
  int unsigned since_q;
  assign rd_any = hsel && hready && htrans[1] && !hwrite;
  assign rd0    = rd_any && (haddr[11:0] == fcs_pkg::REG_CTL_STATUS);
  // cycles since the last erase start, saturating
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) since_q <= 1000;
    else if (arr_erase) since_q <= 0;
    else if (since_q < 1000) since_q <= since_q + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  chk_zero_wait: assert property (hreadyout == 1'b1) else $error("wait state inserted");
  chk_rdata_stands: assert property (!$past(rd_any) |-> $stable(hrdata)) else $error("read data moved");
  chk_erase_pulse: assert property (arr_erase |=> !arr_erase) else $error("erase pulse too long");
  chk_busy_gap: assert property (arr_erase |-> since_q >= 400) else $error("erase started while busy");
  chk_busy_read: assert property (rd0 && since_q < 400 |=> !hrdata[0]) else $error("ready during erase");
  chk_rom_kind: assert property (rd0 |=> hrdata[2] == 1'b0) else $error("rom kind not flash");
  chk_resv_zero: assert property (rd0 |=> hrdata[31:8] == 24'h0) else $error("reserved bits set");
  chk_secure_lock: assert property (rd0 |=> (hrdata[7:4] == 4'hf) == $past(secure))
    else $error("secure disagrees with locks");
  chk_full_erase: assert property (arr_erase && secure |-> arr_erase_all) else $error("secure erase partial");
  chk_lock_late: assert property ($fell(secure) |-> since_q >= 400 && since_q < 1000)
    else $error("locks cleared before erase");
  cover property (arr_erase && arr_erase_all);
  cover property ($fell(secure));
  cover property (rd0 && since_q < 400);
endmodule : fcs_seq_chk
bind fcs_sequencer fcs_seq_chk i_fcs_seq_chk (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .arr_erase(arr_erase), .arr_erase_all(arr_erase_all), .secure(secure));
`default_nettype wire

/* bench/fcs_sequencer_tb_top.sv */
// testbench: flash command sequencer against a flash array model
`default_nettype none
module fcs_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals, instances, tasks
  // ----------------------------------------
  logic        clk = 0, arst_n = 0, hsel = 0, hwrite = 0, fail_arm = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, arr_wdata;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, op_fail, arr_prog, arr_erase, arr_erase_all, arr_chip, secure, last_all;
  logic [20:0] arr_addr;
  int          n_erase, n_fail = 0, comparisons = 0, exp_lock = 0, exp_er = 0, k, seed = 32'h1898ed8f;
  logic [31:0] idv [3] = '{fcs_pkg::ID_MAKER, fcs_pkg::ID_PART, fcs_pkg::ID_KIND};
  always #2 clk = ~clk;
  fcs_sequencer i_fcs_sequencer (.clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .op_fail, .arr_prog, .arr_erase, .arr_erase_all,
    .arr_chip, .arr_addr, .arr_wdata, .secure);
  fcs_arr_model i_fcs_arr_model (.clk, .arst_n, .arr_erase, .arr_erase_all, .fail_arm, .op_fail,
    .n_erase, .last_all);
  task end_of_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task wait_hr;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 100);
    if (i >= 100) begin
      n_fail++;
      end_of_test();
    end
  endtask : wait_hr
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {20'h0, a};
    hwrite <= w;
    wait_hr();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_hr();
    rd = hrdata;
  endtask : ahb
  function automatic logic [31:0] ev(input logic r);
    return {24'h0, exp_lock[3:0], 3'b001, r};
  endfunction : ev
  task ctl(input logic [31:0] e);
    ahb(1'b0, fcs_pkg::REG_CTL_STATUS, 32'h0);
    cmp(rd, e);
  endtask : ctl
  task cmd(input logic [20:0] a, input logic [7:0] d);
    ahb(1'b1, fcs_pkg::REG_CMD_WINDOW, {11'h0, a[20:8], d});
    repeat (16) @(posedge clk);
  endtask : cmd
  task unl(input logic c);
    cmd({c, 20'h05500}, 8'haa);
    cmd({c, 20'h0aa00}, 8'h55);
  endtask : unl
  task seq6(input logic c, input logic [7:0] d3, input logic [20:0] a6, input logic [7:0] d6);
    unl(c);
    cmd({c, 20'h05500}, d3);
    unl(c);
    cmd(a6, d6);
  endtask : seq6
  task lock7(input logic c, input logic [7:0] d, input logic [1:0] s);
    seq6(c, d, {c, 20'h05500}, d);
    cmd({c, 4'h0, s, 14'h0}, d);
  endtask : lock7
  task ready;
    int i;
    i = 0;
    do begin
      ahb(1'b0, fcs_pkg::REG_CTL_STATUS, 32'h0);
      i++;
    end while (rd[0] !== 1'b1 && i < 500);
    if (i >= 500) begin
      n_fail++;
      end_of_test();
    end
  endtask : ready
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    ctl(32'h1);
    ahb(1'b0, 12'h010, 32'h0);
    cmp(rd, 32'h0);
    seq6(1'b0, 8'h80, 21'h05500, 8'h10);
    cmp(n_erase, exp_er);
    ahb(1'b1, fcs_pkg::REG_CTL_STATUS, 32'h2);
    ctl(ev(1'b1));
    lock7(1'b1, 8'h9a, 2'd1);
    ready();
    ctl(ev(1'b1));
    for (k = 0; k < 4; k++) begin
      lock7(1'b0, 8'h9a, k[1:0]);
      exp_lock |= 1 << k;
      ready();
      ctl(ev(1'b1));
    end
    cmp(secure, 1'b1);
    seq6(1'b0, 8'h80, 21'h05500, 8'h10);
    cmp(n_erase, exp_er);
    lock7(1'b0, 8'h6a, 2'd0);
    ctl(ev(1'b0));
    ready();
    exp_lock = 0;
    exp_er++;
    ctl(ev(1'b1));
    cmp(n_erase, exp_er);
    cmp(last_all, 1'b1);
    for (k = 0; k < 4; k++) if (k != 1) begin
      lock7(1'b0, 8'h9a, k[1:0]);
      exp_lock |= 1 << k;
      ready();
    end
    k = {$random(seed)} % 2;
    lock7(1'b0, 8'h6a, {k[0], 1'b0});
    ready();
    exp_lock &= (k != 0) ? 3 : 12;
    ctl(ev(1'b1));
    lock7(1'b1, 8'h6a, 2'd0);
    ready();
    ctl(ev(1'b1));
    for (k = 0; k < 2; k++) begin
      lock7(1'b0, 8'h6a, {k[0], 1'b0});
      ready();
    end
    exp_lock = 0;
    k = {$random(seed)} % 3;
    unl(1'b0);
    cmd(21'h05500, 8'h90);
    repeat (2) begin
      cmd({5'h0, k[1:0], 14'h0}, 8'h00);
      ahb(1'b0, fcs_pkg::REG_ID_DATA, 32'h0);
      cmp(rd, idv[k]);
      k = (k + 1) % 3;
    end
    cmd(21'h0, 8'hf0);
    seq6(1'b1, 8'h80, 21'h105500, 8'h10);
    exp_er++;
    ctl(ev(1'b0));
    seq6(1'b0, 8'h80, 21'h040000, 8'h30);
    ready();
    cmp(n_erase, exp_er);
    cmp(arr_chip, 1'b1);
    seq6(1'b0, 8'h80, 21'h040000, 8'h30);
    exp_er++;
    ready();
    cmp(last_all, 1'b0);
    cmp(arr_chip, 1'b0);
    unl(1'b0);
    cmd(21'h05500, 8'hf0);
    unl(1'b0);
    cmd(21'h05500, 8'h80);
    cmd(21'h05500, 8'haa);
    cmd(21'h05500, 8'h55);
    cmd(21'h05500, 8'h10);
    ctl(ev(1'b1));
    cmp(n_erase, exp_er);
    fail_arm <= 1'b1;
    seq6(1'b0, 8'h80, 21'h05500, 8'h10);
    repeat (600) @(posedge clk);
    fail_arm <= 1'b0;
    repeat (4) @(posedge clk);
    ctl(ev(1'b0));
    cmd(21'h0, 8'hf0);
    ctl(ev(1'b1));
    ahb(1'b1, fcs_pkg::REG_CTL_STATUS, 32'h0);
    ctl(32'h1);
    ahb(1'b1, fcs_pkg::REG_CTL_STATUS, 32'h2);
    seq6(1'b0, 8'h80, 21'h05500, 8'h10);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    ctl(32'h1);
    end_of_test();
  end
endmodule : fcs_sequencer_tb_top
`default_nettype wire

/* design/fcs_pkg.sv */
// package: constants and types for the flash command sequencer
`default_nettype none
package fcs_pkg;
  // ahb-lite register map
  localparam logic [11:0] REG_CTL_STATUS  = 12'h000;
  localparam logic [11:0] REG_CMD_WINDOW  = 12'h004;
  localparam logic [11:0] REG_ID_DATA     = 12'h008;
  localparam logic [11:0] REG_RESULT      = 12'h00c;
  // flash_ctl_status field positions
  localparam int          BIT_DONE        = 0;
  localparam int          BIT_ISSUE       = 1;
  localparam int          BIT_ROMKIND     = 2;
  localparam int          LOCK_LO         = 4;
  // command window address fields
  localparam int          ADDR_CHIP       = 20;
  localparam int          ADDR_CMD_HI     = 15;
  localparam int          ADDR_CMD_LO     = 8;
  localparam int          ADDR_ID_LO      = 14;
  localparam int          ADDR_AREA_LO    = 14;
  localparam logic [7:0]  OFS_55          = 8'h55;
  localparam logic [7:0]  OFS_AA          = 8'haa;
  // command data codes
  localparam logic [7:0]  D_UNLOCK1       = 8'haa;
  localparam logic [7:0]  D_UNLOCK2       = 8'h55;
  localparam logic [7:0]  D_RESET         = 8'hf0;
  localparam logic [7:0]  D_IDREAD        = 8'h90;
  localparam logic [7:0]  D_IDADDR        = 8'h00;
  localparam logic [7:0]  D_PAGE          = 8'ha0;
  localparam logic [7:0]  D_ERASE         = 8'h80;
  localparam logic [7:0]  D_CHIP_ERASE    = 8'h10;
  localparam logic [7:0]  D_BLOCK_ERASE   = 8'h30;
  localparam logic [7:0]  D_LOCK_PROG     = 8'h9a;
  localparam logic [7:0]  D_LOCK_ERASE    = 8'h6a;
  localparam logic [3:0]  LOCK_ALL        = 4'hf;
  localparam logic [3:0]  LOCK_NONE       = 4'h0;
  localparam logic        ROM_KIND_FLASH  = 1'b0;
  localparam logic [31:0] CTL_RESET       = 32'h0000_0001;
  localparam int          PAGE_WORDS      = 4;
  // automatic operation durations (ns) and cycle counts at 250 MHz
  localparam int          CLK_NS          = 4;
  localparam int          T_PROG_NS       = 400;
  localparam int          T_ERASE_NS      = 2000;
  localparam int          PROG_CYC        = T_PROG_NS / CLK_NS;
  localparam int          ERASE_CYC       = T_ERASE_NS / CLK_NS;
  // arbitrary neutral identification values
  localparam logic [31:0] ID_MAKER        = 32'h0000_005a;
  localparam logic [31:0] ID_PART         = 32'h0000_00a5;
  localparam logic [31:0] ID_KIND         = 32'h0000_0011;

  typedef enum logic [1:0] {ACT_NONE, ACT_PROG, ACT_ERASE, ACT_LOCK} fcs_act_t;

  typedef struct packed {
    logic [20:0] addr;
    logic [31:0] data;
  } fcs_cmd_t;
endpackage : fcs_pkg
`default_nettype wire

/* design/fcs_sequencer.sv */
// module: flash command sequencer with ahb-lite control/status registers
//
// Implementation choices: the AHB-Lite slave port and the address map.
`default_nettype none
module fcs_sequencer (
  input  wire logic        clk,          // system clock
  input  wire logic        arst_n,       // async reset, active low
  input  wire logic        hsel,         // ahb slave select
  input  wire logic [31:0] haddr,        // ahb address
  input  wire logic [1:0]  htrans,       // ahb transfer type
  input  wire logic        hwrite,       // ahb write
  input  wire logic [2:0]  hsize,        // ahb size
  input  wire logic [31:0] hwdata,       // ahb write data
  input  wire logic        hready,       // ahb bus ready
  output logic      [31:0] hrdata,       // ahb read data
  output logic             hreadyout,    // ahb slave ready
  output logic             hresp,        // ahb response
  input  wire logic        op_fail,      // array reports failed operation
  output logic             arr_prog,     // pulse: program a word
  output logic             arr_erase,    // pulse: erase request
  output logic             arr_erase_all,// erase is whole array
  output logic             arr_chip,     // array selected for the operation
  output logic      [20:0] arr_addr,     // array word address
  output logic      [31:0] arr_wdata,    // program word
  output logic             secure        // secure state: block outside reads
);
  // ------------------------------------------------------------------
  // ahb-lite slave
  // ------------------------------------------------------------------
  logic        wr_pend_q, rd_pend_q;
  logic [11:0] adr_q;
  logic        issue_q;
  logic [3:0]  lock_q;
  logic        busy_q, fail_q;
  logic        idmode_q;
  logic [1:0]  id_sel_q;
  logic [31:0] id_val;
  logic [2:0]  step_q;
  logic [7:0]  cmd_q;
  logic        chip_q;
  logic [20:0] pa_q;
  logic [2:0]  pw_q;
  fcs_pkg::fcs_act_t act_q;
  logic [15:0] cnt_q;
  logic        erase_all_q;
  logic [1:0]  pair_q;
  logic [1:0]  lockbit_q;

  function automatic logic [7:0] cmd_ofs(input logic [20:0] a);
    cmd_ofs = a[fcs_pkg::ADDR_CMD_HI:fcs_pkg::ADDR_CMD_LO];
  endfunction : cmd_ofs

  wire take = hsel & hready & htrans[1];

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      adr_q     <= 12'h000;
    end else begin
      wr_pend_q <= take & hwrite;
      rd_pend_q <= take & ~hwrite;
      if (take) begin
        adr_q <= haddr[11:0];
      end
    end
  end

  always_comb begin
    unique case (id_sel_q)
      2'h0:    id_val = fcs_pkg::ID_MAKER;
      2'h1:    id_val = fcs_pkg::ID_PART;
      2'h2:    id_val = fcs_pkg::ID_KIND;
      default: id_val = {28'h0000000, lock_q};
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (take & ~hwrite) begin
      unique case (haddr[11:0])
        fcs_pkg::REG_CTL_STATUS: begin
          hrdata                       <= 32'h0000_0000;
          hrdata[fcs_pkg::BIT_DONE]    <= ~busy_q & ~fail_q;
          hrdata[fcs_pkg::BIT_ISSUE]   <= issue_q;
          hrdata[fcs_pkg::BIT_ROMKIND] <= fcs_pkg::ROM_KIND_FLASH;
          hrdata[fcs_pkg::LOCK_LO+:4]  <= lock_q;
        end
        fcs_pkg::REG_ID_DATA: hrdata <= idmode_q ? id_val : 32'h0000_0000;
        fcs_pkg::REG_RESULT:  hrdata <= {29'h0, act_q, fail_q};
        default:              hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // control register
  // ------------------------------------------------------------------
  wire ctl_wr = wr_pend_q & (adr_q == fcs_pkg::REG_CTL_STATUS);
  wire cmd_wr = wr_pend_q & (adr_q == fcs_pkg::REG_CMD_WINDOW);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      issue_q <= fcs_pkg::CTL_RESET[fcs_pkg::BIT_ISSUE];
    end else if (ctl_wr) begin
      issue_q <= hwdata[fcs_pkg::BIT_ISSUE];
    end
  end

  // ------------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------------
  // command window data: bits 20:0 address, byte 0 data; full word for programming
  fcs_pkg::fcs_cmd_t cw;
  assign cw = {hwdata[20:0], hwdata};
  wire [7:0]  d    = hwdata[7:0];
  wire [7:0]  ofs  = cmd_ofs(hwdata[20:0]);
  wire        is55 = (ofs == fcs_pkg::OFS_55);
  wire        isaa = (ofs == fcs_pkg::OFS_AA);
  wire        sec  = (lock_q == fcs_pkg::LOCK_ALL);
  // page writes go to the address held in the command window data field
  wire        cmd_ok = cmd_wr & issue_q & ~busy_q;
  wire        reset_w = cmd_wr & issue_q & (d == fcs_pkg::D_RESET) & ~busy_q;
  wire        fail_clr = cmd_wr & issue_q & (d == fcs_pkg::D_RESET) & fail_q;

  function automatic logic area_locked(input logic [3:0] l, input logic c, input logic a19);
    area_locked = l[{c, a19}];
  endfunction : area_locked

  logic        start_prog, start_erase, start_lock, erase_all_d;
  always_comb begin
    start_prog  = 1'b0;
    start_erase = 1'b0;
    start_lock  = 1'b0;
    erase_all_d = 1'b0;
    if (cmd_ok && !reset_w) begin
      unique case (step_q)
        3'd5: start_erase = (cmd_q == fcs_pkg::D_ERASE) && !sec &&
                            ((is55 && d == fcs_pkg::D_CHIP_ERASE) || d == fcs_pkg::D_BLOCK_ERASE);
        3'd6: start_lock  = (d == cmd_q);
        default: ;
      endcase
      erase_all_d = d == fcs_pkg::D_CHIP_ERASE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      step_q   <= 3'd0;
      cmd_q    <= 8'h00;
      chip_q   <= 1'b0;
      idmode_q <= 1'b0;
      id_sel_q <= 2'h0;
      pair_q   <= 2'h0;
      lockbit_q <= 2'h0;
    end else if (reset_w || fail_clr) begin
      step_q   <= 3'd0;
      idmode_q <= 1'b0;
    end else if (cmd_ok) begin
      step_q <= 3'd0;
      unique case (step_q)
        3'd0: if (isaa == 1'b0 && is55 && d == fcs_pkg::D_UNLOCK1 && !idmode_q) begin
          step_q <= 3'd1;
          chip_q <= hwdata[fcs_pkg::ADDR_CHIP];
        end else if (idmode_q) begin
          id_sel_q <= hwdata[fcs_pkg::ADDR_ID_LO+:2];
        end
        3'd1: if (isaa && d == fcs_pkg::D_UNLOCK2) step_q <= 3'd2;
        3'd2: if (is55) begin
          cmd_q <= d;
          if (d == fcs_pkg::D_IDREAD && !sec) step_q <= 3'd3;
          else if (d == fcs_pkg::D_PAGE && !sec) step_q <= 3'd3;
          else if (d == fcs_pkg::D_ERASE && !sec) step_q <= 3'd3;
          else if (d == fcs_pkg::D_LOCK_PROG && !sec) step_q <= 3'd3;
          else if (d == fcs_pkg::D_LOCK_ERASE) step_q <= 3'd3;
        end
        3'd3: if (cmd_q == fcs_pkg::D_IDREAD) begin
          if (d == fcs_pkg::D_IDADDR) begin
            idmode_q <= 1'b1;
            id_sel_q <= hwdata[fcs_pkg::ADDR_ID_LO+:2];
          end
        end else if (cmd_q != fcs_pkg::D_PAGE && is55 && d == fcs_pkg::D_UNLOCK1) begin
          step_q <= 3'd4;
        end
        3'd4: if (isaa && d == fcs_pkg::D_UNLOCK2) step_q <= 3'd5;
        3'd5: if (is55 && (cmd_q == fcs_pkg::D_LOCK_PROG || cmd_q == fcs_pkg::D_LOCK_ERASE) && d == cmd_q)
          step_q <= 3'd6;
        3'd6: begin
          pair_q    <= {2{hwdata[fcs_pkg::ADDR_AREA_LO+1]}} & 2'b11;
          lockbit_q <= hwdata[fcs_pkg::ADDR_AREA_LO+:2];
        end
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // automatic operation engine
  // ------------------------------------------------------------------
  wire page_start = cmd_ok && step_q == 3'd3 && cmd_q == fcs_pkg::D_PAGE &&
                    !area_locked(lock_q, hwdata[fcs_pkg::ADDR_CHIP], hwdata[19]);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q      <= 1'b0;
      fail_q      <= 1'b0;
      act_q       <= fcs_pkg::ACT_NONE;
      cnt_q       <= 16'h0000;
      erase_all_q <= 1'b0;
      lock_q      <= fcs_pkg::LOCK_NONE;
      pa_q        <= 21'h000000;
      pw_q        <= 3'd0;
      arr_prog    <= 1'b0;
      arr_erase   <= 1'b0;
      arr_addr    <= 21'h000000;
      arr_wdata   <= 32'h0000_0000;
      arr_chip    <= 1'b0;
    end else begin
      arr_prog  <= 1'b0;
      arr_erase <= 1'b0;
      if (fail_clr) begin
        fail_q <= 1'b0;
        busy_q <= 1'b0;
        act_q  <= fcs_pkg::ACT_NONE;
      end else if (page_start) begin
        busy_q    <= 1'b1;
        act_q     <= fcs_pkg::ACT_PROG;
        pa_q      <= hwdata[20:0];
        pw_q      <= 3'd1;
        arr_prog  <= 1'b1;
        arr_addr  <= hwdata[20:0];
        arr_chip  <= hwdata[fcs_pkg::ADDR_CHIP];
        arr_wdata <= hwdata;
        cnt_q     <= 16'(fcs_pkg::PROG_CYC);
      end else if (start_erase) begin
        busy_q      <= 1'b1;
        act_q       <= fcs_pkg::ACT_ERASE;
        erase_all_q <= erase_all_d;
        arr_erase   <= 1'b1;
        arr_chip    <= chip_q;
        arr_addr    <= hwdata[20:0];
        cnt_q       <= 16'(fcs_pkg::ERASE_CYC);
      end else if (start_lock && !chip_q) begin
        busy_q <= 1'b1;
        act_q  <= fcs_pkg::ACT_LOCK;
        if (cmd_q == fcs_pkg::D_LOCK_ERASE && sec) begin
          erase_all_q <= 1'b1;
          arr_erase   <= 1'b1;
          cnt_q       <= 16'(fcs_pkg::ERASE_CYC);
        end else begin
          erase_all_q <= 1'b0;
          cnt_q       <= 16'(fcs_pkg::PROG_CYC);
        end
      end else if (busy_q && !fail_q) begin
        if (op_fail) begin
          fail_q <= 1'b1;
        end else if (act_q == fcs_pkg::ACT_PROG && cmd_wr && pw_q < 3'(fcs_pkg::PAGE_WORDS)) begin
          pw_q      <= pw_q + 3'd1;
          arr_prog  <= 1'b1;
          arr_addr  <= pa_q + 21'({pw_q, 2'b00});
          arr_wdata <= hwdata;
        end else if (cnt_q != 16'h0000) begin
          cnt_q <= cnt_q - 16'h0001;
        end else if (act_q != fcs_pkg::ACT_PROG || pw_q == 3'(fcs_pkg::PAGE_WORDS)) begin
          busy_q <= 1'b0;
          act_q  <= fcs_pkg::ACT_NONE;
          if (act_q == fcs_pkg::ACT_LOCK) begin
            if (cmd_q == fcs_pkg::D_LOCK_PROG) lock_q[lockbit_q] <= 1'b1;
            else if (erase_all_q) lock_q <= fcs_pkg::LOCK_NONE;
            else if (pair_q[0]) lock_q[3:2] <= 2'b00;
            else lock_q[1:0] <= 2'b00;
          end
        end
      end
    end
  end

  assign arr_erase_all = erase_all_q;
  assign secure        = sec;
endmodule : fcs_sequencer
`default_nettype wire
